/* shared/psb_regs.svh */
/*
 * Register offsets, field positions and reset values of the parallel slave
 * buffer status block. Included by the design module, the property module and the test bench.
 */
`ifndef PSB_REGS_SVH
`define PSB_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PSB_STATUS_OFS      12'h000
`define PSB_CTRL_OFS        12'h004
`define PSB_IRQ_STAT_OFS    12'h008
`define PSB_IRQ_MASK_OFS    12'h00c
`define PSB_IN_DATA_OFS     12'h010
`define PSB_OUT_DATA_OFS    12'h020

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSB_ST_OVF_BIT      14
`define PSB_ST_UNF_BIT      6
`define PSB_CTRL_SLAVE_BIT  0
`define PSB_IRQ_OVF_BIT     0
`define PSB_IRQ_UNF_BIT     1
`define PSB_IRQ_RX_BIT      2
`define PSB_IRQ_TX_BIT      3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PSB_CTRL_SLAVE_RST  1'b1
`define PSB_IRQ_MASK_RST    4'h0
`define PSB_IN_FULL_RST     1'b0
`define PSB_OUT_EMPTY_RST   1'b1
`define PSB_STICKY_RST      1'b0

`endif

/* shared/psb_pkg.sv */
/*
 * Types shared by the parallel slave buffer status block.
 * Assumes psb_regs.svh is on the include path.
 */
package psb_pkg;

    // Host-side pins, carried together through the synchroniser
    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] data;
    } psb_host_pins_t;

    // Layout of the buffer status register
    typedef struct packed {
        logic [15:0] zero_hi;
        logic        input_all_full;
        logic        input_overflow_flag;
        logic [1:0]  zero_in;
        logic [3:0]  input_buffer_full_bits;
        logic        output_all_empty;
        logic        output_underflow_flag;
        logic [1:0]  zero_out;
        logic [3:0]  output_buffer_empty_bits;
    } psb_buffer_status_t;

endpackage

/* hw/psb_pin_sync.sv */
/*
 * Three-flop synchroniser plus filtered output flop for asynchronous host pins.
 * Assumes pins may change at any time relative to pclk.
 */
`timescale 1ns/100ps

module psb_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins and result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] agree;
    logic [W-1:0] out_nxt;

    // A change is taken only once the second and third stage agree
    assign agree    = ~(s2_r ^ s3_r);
    assign out_nxt  = (s3_r & agree) | (out_r & ~agree);
    assign pin_sync = out_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            out_r <= '0;
        end else begin
            s1_r  <= pin_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

endmodule

/* hw/psb_status.sv */
/*
 * Parallel slave port buffers with status flags, APB register access and
 * one level interrupt. Input buffers are filled by the external host and
 * drained by the CPU; output buffers run the other way.
 * Assumes host strobes are active high, data and address held stable from
 * at least three pclk cycles before the strobe rises until it falls.
 */
`timescale 1ns/100ps
`include "psb_regs.svh"

module psb_status
    import psb_pkg::*;
#(
    parameter int NUM_BUF = 4,
    parameter int ADDR_W  = 12
) (
    // APB clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Interrupt
    output logic                   irq,
    // Host parallel port
    input  wire logic              host_cs,
    input  wire logic              host_wr,
    input  wire logic              host_rd,
    input  wire logic [1:0]        host_addr,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (NUM_BUF < 1 || NUM_BUF > 4) begin : g_bad_num_buf
        $error("NUM_BUF must lie between 1 and 4");
    end
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("ADDR_W must be at least 6");
    end

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        logic [11:0] a12;
        a12      = 12'(a);
        word_hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[11:2])) && (a12[1:0] == 2'h0);
    endfunction

    function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input logic [11:0] base);
        logic [11:0] a12;
        a12      = 12'(a);
        bank_hit = (a[ADDR_W-1:4] == (ADDR_W-4)'(base[11:4])) && (a12[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m          = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lane_merge = (new_v & m) | (old_v & ~m);
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    // Byte storage
    logic [7:0]         in_buf_r   [NUM_BUF];
    logic [7:0]         out_buf_r  [NUM_BUF];
    logic [NUM_BUF-1:0] in_full_r;
    logic [NUM_BUF-1:0] in_full_nxt;
    logic [NUM_BUF-1:0] out_empty_r;
    logic [NUM_BUF-1:0] out_empty_nxt;

    // Sticky flags and mode
    logic               ovf_r;
    logic               ovf_nxt;
    logic               unf_r;
    logic               unf_nxt;
    logic               slave_mode_r;
    logic               slave_mode_nxt;

    // Interrupt
    logic [3:0]         irq_stat_r;
    logic [3:0]         irq_stat_nxt;
    logic [3:0]         irq_mask_r;
    logic [3:0]         irq_mask_nxt;
    logic               irq_r;

    // Bus answer
    logic [31:0]        prdata_r;
    logic [31:0]        prdata_nxt;
    logic               pready_r;
    logic               pslverr_r;
    logic               pslverr_nxt;

    // Host side
    logic [7:0]         hdout_r;
    logic [7:0]         hdout_nxt;
    logic               hoe_r;
    logic               wr_prev_r;
    logic               rd_prev_r;

    // ------------------------------------------------------------------------
    // Host pin synchronisation and strobe edges
    // ------------------------------------------------------------------------
    psb_host_pins_t host_raw;
    psb_host_pins_t host_sy;

    assign host_raw = '{cs: host_cs, wr: host_wr, rd: host_rd, addr: host_addr, data: host_data_in};

    psb_pin_sync #(
        .W        ($bits(psb_host_pins_t))
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (host_raw),
        .pin_sync (host_sy)
    );

    wire logic [1:0] h_idx     = host_sy.addr;
    wire logic       h_idx_ok  = (32'(h_idx) < NUM_BUF);
    // Host ignored outside slave mode
    wire logic       h_active  = slave_mode_r & host_sy.cs & h_idx_ok;
    wire logic       h_wr_evt  = h_active & host_sy.wr & ~wr_prev_r;
    wire logic       h_rd_evt  = h_active & host_sy.rd & ~rd_prev_r;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire logic       acc       = psel & penable;
    // Answer comes in the second access cycle
    wire logic       acc_first = acc & ~pready_r;
    wire logic       done_ok   = acc & pready_r & ~pslverr_r;
    wire logic       wr_commit = done_ok & pwrite;
    wire logic       rd_commit = done_ok & ~pwrite;
    wire logic [1:0] c_idx     = paddr[3:2];
    wire logic       c_idx_ok  = (32'(c_idx) < NUM_BUF);
    wire logic       hit_stat  = word_hit(paddr, `PSB_STATUS_OFS);
    wire logic       hit_ctrl  = word_hit(paddr, `PSB_CTRL_OFS);
    wire logic       hit_istat = word_hit(paddr, `PSB_IRQ_STAT_OFS);
    wire logic       hit_imask = word_hit(paddr, `PSB_IRQ_MASK_OFS);
    wire logic       hit_in    = bank_hit(paddr, `PSB_IN_DATA_OFS) & c_idx_ok;
    wire logic       hit_out   = bank_hit(paddr, `PSB_OUT_DATA_OFS) & c_idx_ok;
    wire logic       mapped    = hit_stat | hit_ctrl | hit_istat | hit_imask | hit_in | hit_out;
    wire logic       cpu_in_rd = rd_commit & hit_in;
    wire logic       cpu_out_wr = wr_commit & hit_out & pstrb[0];

    // Unwritten status lanes 0 and 1 read as ones: no clear; ctrl and mask keep their value
    wire logic [31:0] wr_stat  = lane_merge(32'h0000_ffff, pwdata, pstrb);
    wire logic [31:0] wr_ctrl  = lane_merge(32'(slave_mode_r), pwdata, pstrb);
    wire logic [31:0] wr_mask  = lane_merge(32'(irq_mask_r), pwdata, pstrb);

    // ------------------------------------------------------------------------
    // Buffers and per-buffer flags
    // ------------------------------------------------------------------------
    logic [NUM_BUF-1:0] h_in_take;
    logic [NUM_BUF-1:0] h_in_ovf;
    logic [NUM_BUF-1:0] h_out_take;
    logic [NUM_BUF-1:0] h_out_unf;
    logic [NUM_BUF-1:0] c_in_clr;
    logic [NUM_BUF-1:0] c_out_fill;

    for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
        wire logic h_sel = (32'(h_idx) == i);
        wire logic c_sel = (32'(c_idx) == i);
        assign c_in_clr[i]   = cpu_in_rd & c_sel;
        assign c_out_fill[i] = cpu_out_wr & c_sel;
        // A CPU read in the same cycle frees the slot, so the byte is kept
        assign h_in_take[i]  = h_wr_evt & h_sel & (~in_full_r[i] | c_in_clr[i]);
        assign h_in_ovf[i]   = h_wr_evt & h_sel & in_full_r[i] & ~c_in_clr[i];
        // A CPU write in the same cycle is forwarded to the host
        assign h_out_take[i] = h_rd_evt & h_sel & (~out_empty_r[i] | c_out_fill[i]);
        assign h_out_unf[i]  = h_rd_evt & h_sel & out_empty_r[i] & ~c_out_fill[i];
        // Set wins over clear on both flags
        assign in_full_nxt[i]   = (in_full_r[i] & ~c_in_clr[i]) | h_in_take[i];
        assign out_empty_nxt[i] = (out_empty_r[i] & ~c_out_fill[i]) | h_rd_evt & h_sel;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                in_buf_r[i]  <= 8'h00;
                out_buf_r[i] <= 8'h00;
            end else begin
                if (h_in_take[i]) begin
                    in_buf_r[i] <= host_sy.data;
                end
                if (c_out_fill[i]) begin
                    out_buf_r[i] <= pwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Aggregate and sticky status
    // ------------------------------------------------------------------------
    wire logic        all_full   = &in_full_r;
    wire logic        all_empty  = &out_empty_r;
    wire logic        ovf_evt    = |h_in_ovf;
    wire logic        unf_evt    = |h_out_unf;
    wire logic        stat_wr    = wr_commit & hit_stat;

    // Software writes zero to clear; a new event in that cycle still sets
    assign ovf_nxt = (ovf_r & ~(stat_wr & ~wr_stat[`PSB_ST_OVF_BIT])) | ovf_evt;
    assign unf_nxt = (unf_r & ~(stat_wr & ~wr_stat[`PSB_ST_UNF_BIT])) | unf_evt;

    psb_buffer_status_t stat_word;
    assign stat_word = '{
        zero_hi:                  16'h0000,
        input_all_full:           all_full,
        input_overflow_flag:      ovf_r,
        zero_in:                  2'h0,
        input_buffer_full_bits:   4'(in_full_r),
        output_all_empty:         all_empty,
        output_underflow_flag:    unf_r,
        zero_out:                 2'h0,
        output_buffer_empty_bits: 4'(out_empty_r)
    };

    // ------------------------------------------------------------------------
    // Control, interrupt status and mask
    // ------------------------------------------------------------------------
    wire logic [3:0] irq_evt;
    assign irq_evt[`PSB_IRQ_OVF_BIT] = ovf_evt;
    assign irq_evt[`PSB_IRQ_UNF_BIT] = unf_evt;
    assign irq_evt[`PSB_IRQ_RX_BIT]  = |h_in_take;
    assign irq_evt[`PSB_IRQ_TX_BIT]  = |h_out_take;

    // Only the bits returned by the read are cleared, so late events survive
    wire logic [3:0] irq_rd_clr = (rd_commit & hit_istat) ? prdata_r[3:0] : 4'h0;

    assign irq_stat_nxt   = (irq_stat_r & ~irq_rd_clr) | irq_evt;
    assign irq_mask_nxt   = (wr_commit & hit_imask) ? wr_mask[3:0] : irq_mask_r;
    assign slave_mode_nxt = (wr_commit & hit_ctrl) ? wr_ctrl[`PSB_CTRL_SLAVE_BIT] : slave_mode_r;

    // ------------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------------
    // Status is meaningless in master mode, so it reads as zero there
    wire logic [31:0] rd_stat  = slave_mode_r ? 32'(stat_word) : 32'h0000_0000;
    wire logic [31:0] rd_word  =
        hit_stat  ? rd_stat :
        hit_ctrl  ? 32'(slave_mode_r) :
        hit_istat ? 32'(irq_stat_r) :
        hit_imask ? 32'(irq_mask_r) :
        hit_in    ? 32'(in_buf_r[c_idx]) :
        hit_out   ? 32'(out_buf_r[c_idx]) : 32'h0000_0000;

    assign prdata_nxt  = (acc_first & ~pwrite) ? rd_word : prdata_r;
    assign pslverr_nxt = acc_first & ~mapped;

    // ------------------------------------------------------------------------
    // Host read data
    // ------------------------------------------------------------------------
    wire logic [7:0] fwd_byte = pstrb[0] ? pwdata[7:0] : out_buf_r[h_idx];
    wire logic       fwd_hit  = cpu_out_wr & (c_idx == h_idx);

    assign hdout_nxt = ~h_rd_evt ? hdout_r :
                       fwd_hit   ? fwd_byte :
                       out_buf_r[h_idx];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Flags, mode and interrupt state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_full_r    <= {NUM_BUF{`PSB_IN_FULL_RST}};
            out_empty_r  <= {NUM_BUF{`PSB_OUT_EMPTY_RST}};
            ovf_r        <= `PSB_STICKY_RST;
            unf_r        <= `PSB_STICKY_RST;
            slave_mode_r <= `PSB_CTRL_SLAVE_RST;
            irq_stat_r   <= 4'h0;
            irq_mask_r   <= `PSB_IRQ_MASK_RST;
        end else begin
            in_full_r    <= in_full_nxt;
            out_empty_r  <= out_empty_nxt;
            ovf_r        <= ovf_nxt;
            unf_r        <= unf_nxt;
            slave_mode_r <= slave_mode_nxt;
            irq_stat_r   <= irq_stat_nxt;
            irq_mask_r   <= irq_mask_nxt;
        end
    end

    // One wait state lets read data come from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            irq_r     <= 1'b0;
        end else begin
            pready_r  <= acc_first;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            irq_r     <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_prev_r <= 1'b0;
            rd_prev_r <= 1'b0;
            hdout_r   <= 8'h00;
            hoe_r     <= 1'b0;
        end else begin
            wr_prev_r <= host_sy.wr;
            rd_prev_r <= host_sy.rd;
            hdout_r   <= hdout_nxt;
            hoe_r     <= slave_mode_r & host_sy.cs & host_sy.rd;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign irq           = irq_r;
    assign host_data_out = hdout_r;
    assign host_data_oe  = hoe_r;

endmodule

/* verification/psb_host_model.sv */
/* External host model: strobed byte writes and reads on the host pins.
   Assumes each task is called right after a rising pclk edge. */
`timescale 1ns/100ps

module psb_host_model (
    // Clock
    input  wire logic       pclk,
    // Host pins
    output logic            host_cs,
    output logic            host_wr,
    output logic            host_rd,
    output logic [1:0]      host_addr,
    output logic [7:0]      host_data_in,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe
);
    initial begin
        host_cs      = 1'b0;
        host_wr      = 1'b0;
        host_rd      = 1'b0;
        host_addr    = 2'h0;
        host_data_in = 8'h00;
    end

    // Lines settle well before the strobe so the pin sync sees them
    task automatic setup(input logic [1:0] a, input logic [7:0] d);
        @(posedge pclk);
        host_cs      <= 1'b1;
        host_addr    <= a;
        host_data_in <= d;
        repeat (4) @(posedge pclk);
    endtask

    // Released lines show the inverse, never the stale value
    task automatic release_lines(input logic [1:0] a, input logic [7:0] d);
        repeat (4) @(posedge pclk);
        host_cs      <= 1'b0;
        host_addr    <= ~a;
        host_data_in <= ~d;
        repeat (6) @(posedge pclk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d, input int hl);
        setup(a, d);
        host_wr <= 1'b1;
        repeat (hl) @(posedge pclk);
        host_wr <= 1'b0;
        release_lines(a, d);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] q, output logic oe, input int hl);
        setup(a, host_data_in);
        host_rd <= 1'b1;
        repeat (hl) @(posedge pclk);
        @(negedge pclk);
        q  = host_data_out;
        oe = host_data_oe;
        @(posedge pclk);
        host_rd <= 1'b0;
        release_lines(a, host_data_in);
    endtask
endmodule

/* verification/psb_status_properties.sv */
/* Port assertions for psb_status, bound into every instance.
   Assumes the APB master holds each request until pready. */
`timescale 1ns/100ps
`include "psb_regs.svh"

module psb_status_properties #(
    parameter int NUM_BUF = 4,
    parameter int ADDR_W  = 12
) (
    // Clock, reset and APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    // Host pins
    input wire logic              host_cs,
    input wire logic              host_wr,
    input wire logic              host_rd,
    input wire logic [1:0]        host_addr,
    input wire logic [7:0]        host_data_in,
    input wire logic [7:0]        host_data_out,
    input wire logic              host_data_oe
);
    logic slave_r;
    wire  done     = psel & penable & pready & ~pslverr;
    wire  st_rd    = done & ~pwrite & (paddr == `PSB_STATUS_OFS);
    wire  ctrl_wr  = done & pwrite & pstrb[0] & (paddr == `PSB_CTRL_OFS);
    wire  mask_clr = done & pwrite & pstrb[0] & (paddr == `PSB_IRQ_MASK_OFS) & (pwdata[3:0] == 4'h0);
    wire  slave_nxt = ctrl_wr ? pwdata[0] : slave_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) slave_r <= `PSB_CTRL_SLAVE_RST;
        else slave_r <= slave_nxt;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_status_zero_bits: assert property (
        st_rd |-> prdata[31:16] == 16'h0 && prdata[13:12] == 2'h0 && prdata[5:4] == 2'h0)
        else $error("reserved status bits not zero");
    a_all_full_and: assert property (st_rd |-> prdata[15] == (&prdata[11:8]))
        else $error("all-full flag disagrees with full bits");
    a_all_empty_and: assert property (st_rd |-> prdata[7] == (&prdata[3:0]))
        else $error("all-empty flag disagrees with empty bits");
    a_slave_off_zero: assert property (st_rd && !slave_r |-> prdata == 32'h0)
        else $error("status not zero outside slave mode");
    a_ready_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready ##1 !pready)
        else $error("pready not a single pulse after one wait state");
    a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an access completion");
    a_irq_mask_off: assert property (mask_clr |-> ##2 !irq [*3])
        else $error("irq high with all sources masked");
    a_oe_idle_low: assert property (!host_rd [*8] |-> !host_data_oe)
        else $error("host data driven with no read strobe");

    c_all_full: cover property (st_rd && prdata[15]);
    c_overflow: cover property (st_rd && prdata[14]);
    c_underflow: cover property (st_rd && prdata[6]);
    c_irq: cover property (irq);
endmodule

bind psb_status psb_status_properties #(.NUM_BUF(NUM_BUF), .ADDR_W(ADDR_W)) props_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .irq, .host_cs, .host_wr, .host_rd, .host_addr, .host_data_in, .host_data_out,
    .host_data_oe);

/* verification/test_parallel_slave_buffer_status.sv */
/* Self-checking bench: APB master, host model and status expectations.
   Assumes psb_pkg and psb_regs.svh are compiled and on the path. */
`timescale 1ns/100ps
`include "psb_regs.svh"

module test_parallel_slave_buffer_status import psb_pkg::*; ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, ho;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, xs;
    logic [3:0]  pstrb, in_full, out_empty;
    logic        host_cs, host_wr, host_rd, host_data_oe, ovf, unf;
    logic [1:0]  host_addr;
    logic [7:0]  host_data_in, host_data_out, hb;
    logic [7:0]  bytes [4];
    int          errors, num_checks;

    psb_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .irq, .host_cs, .host_wr, .host_rd, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe);
    psb_host_model host_u (.pclk, .host_cs, .host_wr, .host_rd, .host_addr, .host_data_in,
        .host_data_out, .host_data_oe);

    function automatic logic [31:0] nxt();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction

    function automatic logic [31:0] exp_st(input logic sl);
        psb_buffer_status_t s;
        s = '0;
        s.input_all_full           = &in_full;
        s.input_overflow_flag      = ovf;
        s.input_buffer_full_bits   = in_full;
        s.output_all_empty         = &out_empty;
        s.output_underflow_flag    = unf;
        s.output_buffer_empty_bits = out_empty;
        return sl ? s : 32'h0;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        num_checks++;
        if (g !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st_chk(input logic sl);
        apb(1'b0, `PSB_STATUS_OFS, 32'h0);
        chk("status", exp_st(sl), q);
    endtask

    task automatic irq_chk(input logic ex);
        repeat (3) @(negedge pclk);
        chk("irq", 32'(ex), 32'(irq));
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        complete_run();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        {errors, num_checks, ovf, unf, in_full} = '0;
        out_empty = 4'hf;
        xs = 32'hb238;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `PSB_CTRL_OFS, 32'h0);
        chk("ctrl", 32'h1, q);
        apb(1'b0, `PSB_IRQ_MASK_OFS, 32'h0);
        chk("mask", 32'h0, q);
        st_chk(1'b1);
        apb(1'b0, 12'h030, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        $display("test reset done");
        apb(1'b1, `PSB_IRQ_MASK_OFS, 32'h3);
        for (int i = 0; i < 4; i++) begin
            bytes[i] = 8'(nxt());
            host_u.wr(2'(i), bytes[i], 6 + int'(nxt() % 4));
            in_full[i] = 1'b1;
            st_chk(1'b1);
        end
        host_u.wr(2'h2, 8'h5a, 7);
        ovf = 1'b1;
        st_chk(1'b1);
        irq_chk(1'b1);
        apb(1'b0, `PSB_IRQ_STAT_OFS, 32'h0);
        chk("irq_stat", 32'h5, q & 32'hf);
        irq_chk(1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, `PSB_IN_DATA_OFS + 12'(4 * i), 32'h0);
            chk("in_data", 32'(bytes[i]), 32'(q[7:0]));
            in_full[i] = 1'b0;
            st_chk(1'b1);
        end
        apb(1'b1, `PSB_STATUS_OFS, 32'h0);
        ovf = 1'b0;
        st_chk(1'b1);
        $display("test input buffers done");
        for (int i = 0; i < 4; i++) begin
            bytes[i] = 8'(nxt());
            apb(1'b1, `PSB_OUT_DATA_OFS + 12'(4 * i), 32'(bytes[i]));
            out_empty[i] = 1'b0;
            st_chk(1'b1);
        end
        host_u.rd(2'h1, hb, ho, 7 + int'(nxt() % 4));
        chk("host_data", 32'(bytes[1]), 32'(hb));
        chk("host_oe", 32'h1, 32'(ho));
        out_empty[1] = 1'b1;
        st_chk(1'b1);
        host_u.rd(2'h1, hb, ho, 8);
        unf = 1'b1;
        st_chk(1'b1);
        irq_chk(1'b1);
        apb(1'b1, `PSB_STATUS_OFS, 32'h0);
        unf = 1'b0;
        st_chk(1'b1);
        apb(1'b0, `PSB_IRQ_STAT_OFS, 32'h0);
        chk("irq_stat", 32'h2, q & 32'h2);
        irq_chk(1'b0);
        apb(1'b1, `PSB_IRQ_MASK_OFS, 32'h0);
        host_u.rd(2'h1, hb, ho, 9);
        unf = 1'b1;
        st_chk(1'b1);
        irq_chk(1'b0);
        $display("test output buffers done");
        apb(1'b1, `PSB_CTRL_OFS, 32'h0);
        st_chk(1'b0);
        host_u.wr(2'h0, 8'hc3, 8);
        apb(1'b1, `PSB_CTRL_OFS, 32'h1);
        st_chk(1'b1);
        apb(1'b1, `PSB_STATUS_OFS, 32'h0);
        unf = 1'b0;
        for (int i = 0; i < 4; i += 1 + int'(i == 0)) begin
            host_u.rd(2'(i), hb, ho, 7 + int'(nxt() % 4));
            chk("host_data", 32'(bytes[i]), 32'(hb));
            out_empty[i] = 1'b1;
        end
        st_chk(1'b1);
        $display("test slave mode and drain done");
        complete_run();
    end
endmodule
